// *** pkg/pss_regs.vh ***
/*
 * Register offsets, field positions, reset values, opcodes and timing counts
 * for the program sequencer. Assumes inclusion by bare name from rtl files.
 */
`ifndef PSS_REGS_VH
`define PSS_REGS_VH

// Register byte offsets
`define PSS_OFF_CTRL        12'h000
`define PSS_OFF_PC_LOW      12'h004
`define PSS_OFF_TBL_PTR_LO  12'h008
`define PSS_OFF_TBL_PTR_HI  12'h00c
`define PSS_OFF_TBL_HIGH    12'h010
`define PSS_OFF_STATUS      12'h014
`define PSS_OFF_LOAD_ADDR   12'h018
`define PSS_OFF_LOAD_DATA   12'h01c

// Field positions and reset values
`define PSS_CTRL_RUN_BIT    0
`define PSS_CTRL_RST        1'b0
`define PSS_PTR_HI_W        5
`define PSS_LAST_PAGE       5'h1f
`define PSS_FLAGS_W         4
`define PSS_STAT_TBL_BUSY   4
`define PSS_STAT_DUMMY      5
`define PSS_STAT_STK_FULL   6

// Widths and sizes
`define PSS_PC_W            13
`define PSS_WORD_W          16
`define PSS_MEM_DEPTH       8192
`define PSS_STACK_DEPTH     8
`define PSS_STACK_PTR_W     3
`define PSS_STACK_CNT_W     4
`define PSS_RESET_VECTOR    13'h0000

// Opcode classes presented by the decoder
`define PSS_OP_SEQ          3'h0
`define PSS_OP_JMP          3'h1
`define PSS_OP_CALL         3'h2
`define PSS_OP_RTN          3'h3
`define PSS_OP_IRTN         3'h4
`define PSS_OP_SKIP         3'h5
`define PSS_OP_TABRD        3'h6
`define PSS_OP_PCLW         3'h7

// Timing: four system clocks form one instruction cycle
`define PSS_PHASES          4
`define PSS_PHASE_W         2

`endif

// *** rtl/pss_ret_stack.v ***
/*
 * Eight-level return-address stack with a level count.
 * Assumes push and pop are never requested in the same cycle.
 */
`timescale 1ns/1ps
`include "pss_regs.vh"

module pss_ret_stack (
    // Clock and reset
    input  wire                          pclk,
    input  wire                          presetn,
    // Stack operations
    input  wire                          push,
    input  wire                          pop,
    input  wire [`PSS_PC_W-1:0]          push_addr,
    // Stack state
    output wire [`PSS_PC_W-1:0]          top_addr,
    output wire                          full,
    output wire                          empty
);

    reg [`PSS_PC_W-1:0]       level_mem [0:`PSS_STACK_DEPTH-1];
    reg [`PSS_STACK_PTR_W-1:0] wr_ptr_q;
    reg [`PSS_STACK_CNT_W-1:0] count_q;
    wire [`PSS_STACK_PTR_W-1:0] top_ptr;

    assign top_ptr  = wr_ptr_q - 3'h1;
    assign top_addr = level_mem[top_ptr];
    assign full     = (count_q == 4'h8);
    assign empty    = (count_q == 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // Circular storage: a push when full overwrites the oldest entry
    always @(posedge pclk) begin
        if (push) begin
            level_mem[wr_ptr_q] <= push_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointer and level count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= 3'h0;
            count_q  <= 4'h0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 3'h1;
            if (!full) begin
                count_q <= count_q + 4'h1;
            end
        end else if (pop) begin
            wr_ptr_q <= top_ptr;
            if (!empty) begin
                count_q <= count_q - 4'h1;
            end
        end
    end

endmodule // pss_ret_stack

// *** rtl/pss_sequencer.v ***
/*
 * Program sequencer: program counter, branch and skip dummy cycles, return
 * stack, status flags, table reads from program memory, APB registers.
 * Assumes the decoder presents one opcode class per accepted instruction
 * cycle on pclk, and an interrupt controller holding its request level.
 */
// Decided for this implementation: the address map and the APB interface to the registers.
// Function
// - Program counter steps by one after each sequential instruction.
// - Software reaches only the low eight program-address bits.
// - Jump, call, interrupt and reset load the target into the counter.
// - Taken skip discards the prefetched instruction and runs a dummy cycle.
// - Low-byte write jumps inside the current 256-word page with a dummy cycle.
// - Return stack has eight levels, invisible to software.
// - Call or interrupt acknowledge pushes the program address.
// - Return or interrupt return pops the stack into the counter.
// - Reset leaves the stack pointer at the empty top.
// - Full stack holds off interrupt acknowledge until a return pops.
// - Call on full stack proceeds and loses the oldest saved address.
// - ALU results update the status flags.
// - Program memory holds 8K sixteen-bit words, fetched and table-read.
// - After reset execution starts fetching at address zero.
// - Table address comes from the low and high table pointers, or from the low pointer in the top page for the last-page variant.
// - Table read delivers the low word byte to the named data register.
// - Table read loads the high word byte into the table-high latch.
// - Each table read takes two instruction cycles.
// - Table-high latch is software readable and writable.
// - Jump or call costs one extra instruction cycle.
`timescale 1ns/1ps
`include "pss_regs.vh"

module pss_sequencer (
    // Clock and reset
    input  wire                          pclk,
    input  wire                          presetn,
    // APB slave
    input  wire                          psel,
    input  wire                          penable,
    input  wire                          pwrite,
    input  wire [11:0]                   paddr,
    input  wire [31:0]                   pwdata,
    output reg  [31:0]                   prdata,
    output wire                          pready,
    output wire                          pslverr,
    // Decoder opcode
    input  wire [2:0]                    op_class,
    input  wire [`PSS_PC_W-1:0]          op_target,
    input  wire [7:0]                    op_data,
    input  wire                          op_last_page,
    output wire                          op_accept,
    // Fetch
    output wire [`PSS_PC_W-1:0]          fetch_addr,
    output reg  [`PSS_WORD_W-1:0]        fetch_word,
    output wire                          fetch_discard,
    // Interrupt controller
    input  wire                          irq_pending,
    input  wire [`PSS_PC_W-1:0]          irq_vector,
    output reg                           irq_ack,
    // ALU status
    input  wire                          alu_valid,
    input  wire [`PSS_FLAGS_W-1:0]       alu_flags,
    output reg  [`PSS_FLAGS_W-1:0]       status_flags,
    // Table read result
    output reg  [7:0]                    tbl_low_data,
    output reg                           tbl_low_valid
);

    localparam [1:0] ST_EXEC  = 2'h0;
    localparam [1:0] ST_DUMMY = 2'h1;
    localparam [1:0] ST_TBL   = 2'h2;

    reg  [`PSS_WORD_W-1:0]      prog_mem [0:`PSS_MEM_DEPTH-1];
    reg  [`PSS_PHASE_W-1:0]     phase_q;
    reg  [1:0]                  state_q;
    reg  [1:0]                  state_d;
    reg  [`PSS_PC_W-1:0]        pc_q;
    reg  [`PSS_PC_W-1:0]        pc_d;
    reg                         run_q;
    reg  [7:0]                  tbl_ptr_lo_q;
    reg  [`PSS_PTR_HI_W-1:0]    tbl_ptr_hi_q;
    reg  [7:0]                  tbl_high_q;
    reg  [`PSS_PC_W-1:0]        tbl_addr_q;
    reg  [`PSS_PC_W-1:0]        load_addr_q;
    reg                         low_pend_q;
    reg  [7:0]                  low_val_q;
    reg                         push;
    reg                         pop;
    reg  [`PSS_PC_W-1:0]        push_addr;
    reg                         tbl_start;
    reg                         low_take;
    wire                        cyc_en;
    wire                        irq_take;
    wire                        exec_slot;
    wire [`PSS_PC_W-1:0]        pc_inc;
    wire [`PSS_PC_W-1:0]        top_addr;
    wire                        stk_full;
    wire                        stk_empty;
    wire                        apb_wr;
    wire                        apb_rd;
    wire                        addr_ok;
    wire [`PSS_WORD_W-1:0]      tbl_word;

    ////////////////////////////////////////////////////////////////////////
    // Instruction cycle enable: one pulse per four system clocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 2'h0;
        end else if (run_q) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign cyc_en    = run_q && (phase_q == 2'h3);
    assign exec_slot = cyc_en && (state_q == ST_EXEC);
    // Full stack holds the acknowledge; the request stays with its owner
    assign irq_take  = exec_slot && irq_pending && !stk_full;
    assign op_accept = exec_slot && !irq_take && !low_pend_q;
    assign pc_inc    = pc_q + 13'h0001;
    assign fetch_addr    = pc_q;
    assign fetch_discard = (state_q == ST_DUMMY);

    ////////////////////////////////////////////////////////////////////////
    // Sequencing decisions
    always @* begin
        state_d   = state_q;
        pc_d      = pc_q;
        push      = 1'b0;
        pop       = 1'b0;
        push_addr = pc_inc;
        tbl_start = 1'b0;
        low_take  = 1'b0;
        if (cyc_en) begin
            case (state_q)
                ST_EXEC: begin
                    if (irq_take) begin
                        push      = 1'b1;
                        push_addr = pc_q;
                        pc_d      = irq_vector;
                        state_d   = ST_DUMMY;
                    end else if (low_pend_q) begin
                        low_take = 1'b1;
                        pc_d     = {pc_q[12:8], low_val_q};
                        state_d  = ST_DUMMY;
                    end else begin
                        case (op_class)
                            `PSS_OP_SEQ: begin
                                pc_d = pc_inc;
                            end
                            `PSS_OP_JMP: begin
                                pc_d    = op_target;
                                state_d = ST_DUMMY;
                            end
                            `PSS_OP_CALL: begin
                                push    = 1'b1;
                                pc_d    = op_target;
                                state_d = ST_DUMMY;
                            end
                            `PSS_OP_RTN, `PSS_OP_IRTN: begin
                                pop     = 1'b1;
                                pc_d    = top_addr;
                                state_d = ST_DUMMY;
                            end
                            `PSS_OP_SKIP: begin
                                pc_d    = pc_q + 13'h0002;
                                state_d = ST_DUMMY;
                            end
                            `PSS_OP_TABRD: begin
                                tbl_start = 1'b1;
                                state_d   = ST_TBL;
                            end
                            `PSS_OP_PCLW: begin
                                pc_d    = {pc_q[12:8], op_data};
                                state_d = ST_DUMMY;
                            end
                            default: begin
                                pc_d = pc_inc;
                            end
                        endcase
                    end
                end
                ST_DUMMY: begin
                    state_d = ST_EXEC;
                end
                ST_TBL: begin
                    pc_d    = pc_inc;
                    state_d = ST_EXEC;
                end
                default: begin
                    state_d = ST_EXEC;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter and state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q    <= `PSS_RESET_VECTOR;
            state_q <= ST_EXEC;
        end else begin
            pc_q    <= pc_d;
            state_q <= state_d;
        end
    end

    pss_ret_stack u_stack (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (push),
        .pop       (pop),
        .push_addr (push_addr),
        .top_addr  (top_addr),
        .full      (stk_full),
        .empty     (stk_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // Program memory: fetch, table read and software load port
    assign tbl_word = prog_mem[tbl_addr_q];

    always @(posedge pclk) begin
        fetch_word <= prog_mem[pc_q];
        if (apb_wr && (paddr == `PSS_OFF_LOAD_DATA)) begin
            prog_mem[load_addr_q] <= pwdata[15:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack       <= 1'b0;
            tbl_addr_q    <= 13'h0000;
            tbl_low_data  <= 8'h00;
            tbl_low_valid <= 1'b0;
            status_flags  <= 4'h0;
        end else begin
            irq_ack       <= irq_take;
            tbl_low_valid <= 1'b0;
            if (tbl_start) begin
                // Last-page variant forces the top page
                tbl_addr_q <= op_last_page ? {`PSS_LAST_PAGE, tbl_ptr_lo_q}
                                           : {tbl_ptr_hi_q, tbl_ptr_lo_q};
            end
            if (cyc_en && (state_q == ST_TBL)) begin
                tbl_low_data  <= tbl_word[7:0];
                tbl_low_valid <= 1'b1;
            end
            if (alu_valid) begin
                status_flags <= alu_flags;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB registers; slave answers with no wait states
    assign pready  = 1'b1;
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && penable && !pwrite;
    assign addr_ok = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
    assign pslverr = psel && penable && !addr_ok;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q        <= `PSS_CTRL_RST;
            tbl_ptr_lo_q <= 8'h00;
            tbl_ptr_hi_q <= 5'h00;
            tbl_high_q   <= 8'h00;
            load_addr_q  <= 13'h0000;
            low_pend_q   <= 1'b0;
            low_val_q    <= 8'h00;
        end else begin
            // A new write wins over the retiring jump
            if (apb_wr && (paddr == `PSS_OFF_PC_LOW)) begin
                low_pend_q <= 1'b1;
                low_val_q  <= pwdata[7:0];
            end else if (low_take) begin
                low_pend_q <= 1'b0;
            end
            if (apb_wr && (paddr == `PSS_OFF_CTRL)) begin
                run_q <= pwdata[`PSS_CTRL_RUN_BIT];
            end
            if (apb_wr && (paddr == `PSS_OFF_TBL_PTR_LO)) begin
                tbl_ptr_lo_q <= pwdata[7:0];
            end
            if (apb_wr && (paddr == `PSS_OFF_TBL_PTR_HI)) begin
                tbl_ptr_hi_q <= pwdata[4:0];
            end
            // Hardware load in the same cycle beats a software write
            if (cyc_en && (state_q == ST_TBL)) begin
                tbl_high_q <= tbl_word[15:8];
            end else if (apb_wr && (paddr == `PSS_OFF_TBL_HIGH)) begin
                tbl_high_q <= pwdata[7:0];
            end
            if (apb_wr && (paddr == `PSS_OFF_LOAD_ADDR)) begin
                load_addr_q <= pwdata[12:0];
            end else if (apb_wr && (paddr == `PSS_OFF_LOAD_DATA)) begin
                load_addr_q <= load_addr_q + 13'h0001;
            end
        end
    end

    always @* begin
        prdata = 32'h00000000;
        if (apb_rd) begin
            case (paddr)
                `PSS_OFF_CTRL:       prdata = {31'h0, run_q};
                `PSS_OFF_PC_LOW:     prdata = {24'h0, pc_q[7:0]};
                `PSS_OFF_TBL_PTR_LO: prdata = {24'h0, tbl_ptr_lo_q};
                `PSS_OFF_TBL_PTR_HI: prdata = {27'h0, tbl_ptr_hi_q};
                `PSS_OFF_TBL_HIGH:   prdata = {24'h0, tbl_high_q};
                `PSS_OFF_STATUS:     prdata = {25'h0, stk_full, (state_q == ST_DUMMY),
                                               (state_q == ST_TBL), status_flags};
                `PSS_OFF_LOAD_ADDR:  prdata = {19'h0, load_addr_q};
                default:             prdata = 32'h00000000;
            endcase
        end
    end

endmodule // pss_sequencer

// *** test/pss_seq_properties.sv ***
/* Port-level properties of the program sequencer.
   Assumes it is bound onto pss_sequencer, one pclk domain. */
`timescale 1ns/1ps
`include "pss_regs.vh"
module pss_seq_properties (
    // Clock and reset
    input logic        pclk,
    input logic        presetn,
    // APB
    input logic        psel,
    input logic        penable,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic        pslverr,
    // Opcode, fetch, interrupt, status, table
    input logic [2:0]  op_class,
    input logic [7:0]  op_data,
    input logic        op_accept,
    input logic [12:0] fetch_addr,
    input logic        fetch_discard,
    input logic [12:0] irq_vector,
    input logic        irq_ack,
    input logic        alu_valid,
    input logic [3:0]  alu_flags,
    input logic [3:0]  status_flags,
    input logic        tbl_low_valid
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire br = op_accept && (op_class == `PSS_OP_JMP || op_class == `PSS_OP_CALL);
////////////////////////////////////////////////////////////////////////////////
property p_seq; op_accept && op_class == `PSS_OP_SEQ |=> fetch_addr == $past(fetch_addr) + 13'h1; endproperty
a_seq: assert property (p_seq) else $error("pc did not step by one");
property p_branch; br |=> fetch_discard[*4] ##1 !fetch_discard; endproperty
a_branch: assert property (p_branch) else $error("branch dummy cycle wrong");
property p_skip; op_accept && op_class == `PSS_OP_SKIP |=> fetch_addr == $past(fetch_addr) + 13'h2 && fetch_discard; endproperty
a_skip: assert property (p_skip) else $error("skip did not discard");
property p_pclw; op_accept && op_class == `PSS_OP_PCLW |=> fetch_addr == {$past(fetch_addr[12:8]), $past(op_data)} && fetch_discard; endproperty
a_pclw: assert property (p_pclw) else $error("in-page jump wrong");
property p_gap; op_accept |=> !op_accept[*3]; endproperty
a_gap: assert property (p_gap) else $error("accept faster than one per cycle");
property p_tbl; op_accept && op_class == `PSS_OP_TABRD |=> !tbl_low_valid[*2] ##[1:4] tbl_low_valid; endproperty
a_tbl: assert property (p_tbl) else $error("table read timing wrong");
property p_flags; alu_valid |=> status_flags == $past(alu_flags); endproperty
a_flags: assert property (p_flags) else $error("flags not updated");
property p_irq; irq_ack |-> fetch_addr == irq_vector && fetch_discard ##1 !irq_ack; endproperty
a_irq: assert property (p_irq) else $error("interrupt entry wrong");
property p_slverr; psel && penable && paddr[11:5] != 7'h0 |-> pslverr && prdata == 32'h0; endproperty
a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
property p_rst; $rose(presetn) |-> fetch_addr == 13'h0 && !op_accept; endproperty
a_rst: assert property (p_rst) else $error("pc not zero after reset");
endmodule // pss_seq_properties
bind pss_sequencer pss_seq_properties pss_seq_properties_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .op_class(op_class), .op_data(op_data), .op_accept(op_accept), .fetch_addr(fetch_addr),
    .fetch_discard(fetch_discard), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .alu_valid(alu_valid), .alu_flags(alu_flags), .status_flags(status_flags),
    .tbl_low_valid(tbl_low_valid));

// *** test/tb_program_sequencer_stack_table_read.sv ***
/* Self-checking bench: opcode table loop, then registers, stack and interrupt.
   Assumes pss_regs.vh on the include path and pready without wait limit. */
`timescale 1ns/1ps
`include "pss_regs.vh"
module tb_program_sequencer_stack_table_read;
typedef struct packed {
    logic [2:0]  cls;
    logic [12:0] tgt;
    logic [7:0]  dat;
    logic        lp;
    logic [12:0] pcn;
    logic [3:0]  gap;
    logic [12:0] tbl;
} pss_row_t;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rd;
logic        op_last_page = 0, op_accept, fetch_discard, slv;
logic [2:0]  op_class = 0;
logic [12:0] op_target = 0, fetch_addr, irq_vector = 13'h0800, tbl_exp = 0, pc;
logic [7:0]  op_data = 0, tbl_low_data;
logic [15:0] fetch_word;
logic        irq_pending = 0, irq_ack, alu_valid = 0, tbl_low_valid;
logic [3:0]  alu_flags = 0, status_flags;
int          error_cnt = 0, n_compared = 0, cyc = 0, n_ack = 0, n_tbl = 0, k;
logic [12:0] ld [14] = '{0, 1, 'h123, 'h124, 'h1abc, 'h1abd, 'h200, 'h126, 'h155, 'h156,
                        'h157, 'h158, 'h1f06, 'h306};
pss_row_t    rows [11] = '{
    '{`PSS_OP_SEQ, 0, 0, 0, 'h001, 4, 0}, '{`PSS_OP_JMP, 'h123, 0, 0, 'h123, 8, 0},
    '{`PSS_OP_CALL, 'h1abc, 0, 0, 'h1abc, 8, 0}, '{`PSS_OP_CALL, 'h200, 0, 0, 'h200, 8, 0},
    '{`PSS_OP_RTN, 0, 0, 0, 'h1abd, 8, 0}, '{`PSS_OP_IRTN, 0, 0, 0, 'h124, 8, 0},
    '{`PSS_OP_SKIP, 0, 0, 0, 'h126, 8, 0}, '{`PSS_OP_PCLW, 0, 'h55, 0, 'h155, 8, 0},
    '{`PSS_OP_TABRD, 0, 0, 1, 'h156, 8, 'h1f06}, '{`PSS_OP_TABRD, 0, 0, 0, 'h157, 8, 'h306},
    '{`PSS_OP_SEQ, 0, 0, 0, 'h158, 4, 0}};

pss_sequencer pss_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_class(op_class), .op_target(op_target), .op_data(op_data),
    .op_last_page(op_last_page), .op_accept(op_accept), .fetch_addr(fetch_addr),
    .fetch_word(fetch_word), .fetch_discard(fetch_discard), .irq_pending(irq_pending),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .alu_valid(alu_valid), .alu_flags(alu_flags),
    .status_flags(status_flags), .tbl_low_data(tbl_low_data), .tbl_low_valid(tbl_low_valid));
////////////////////////////////////////////////////////////////////////////////
always #2.5 pclk = ~pclk;
function automatic logic [15:0] mw(input logic [12:0] a);
    return {3'b101, a};
endfunction
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
        error_cnt++;
        $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
endtask
task automatic print_verdict;
    $display("compares %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel    <= 0;
    penable <= 0;
endtask
// Waits for acceptance; checks the pc seen just before the accepting edge
task automatic op(input logic [2:0] c, input logic [12:0] t, input logic [7:0] d,
                  input logic lp, input logic [12:0] pc_exp);
    op_class     <= c;
    op_target    <= t;
    op_data      <= d;
    op_last_page <= lp;
    k = 0;
    do begin
        @(posedge pclk);
        k++;
    end while (op_accept !== 1'b1 && k < 64);
    chk(fetch_addr, pc_exp);
endtask
////////////////////////////////////////////////////////////////////////////////
always @(posedge pclk) begin
    cyc++;
    if (irq_ack === 1'b1) begin
        n_ack++;
        irq_pending <= 0;
    end
    if (tbl_low_valid === 1'b1) begin
        n_tbl++;
        chk(tbl_low_data, tbl_exp[7:0]);
    end
    // Ceiling well above the few hundred cycles the sequence needs
    if (cyc == 20000) begin
        error_cnt++;
        print_verdict();
    end
end
initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `PSS_OFF_STATUS, 0);
    chk(rd, 0);
    apb(0, `PSS_OFF_PC_LOW, 0);
    chk(rd, 0);
    foreach (ld[i]) begin
        apb(1, `PSS_OFF_LOAD_ADDR, ld[i]);
        apb(1, `PSS_OFF_LOAD_DATA, mw(ld[i]));
    end
    apb(1, `PSS_OFF_TBL_PTR_LO, 32'h06);
    apb(1, `PSS_OFF_TBL_PTR_HI, 32'h03);
    apb(1, `PSS_OFF_CTRL, 32'h1);
    pc = 0;
    for (int i = 0; i < 11; i++) begin
        if (i > 0) tbl_exp = rows[i-1].tbl;
        op(rows[i].cls, rows[i].tgt, rows[i].dat, rows[i].lp, pc);
        chk(fetch_word, mw(pc));
        if (i > 0) chk(k, rows[i-1].gap);
        pc = rows[i].pcn;
    end
    chk(n_tbl, 2);
    apb(0, `PSS_OFF_TBL_HIGH, 0);
    chk(rd, 32'ha3);
    apb(1, `PSS_OFF_TBL_HIGH, 32'h3c);
    apb(0, `PSS_OFF_TBL_HIGH, 0);
    chk(rd, 32'h3c);
    apb(0, 12'h020, 0);
    chk(slv, 1);
    chk(rd, 0);
    alu_flags <= 4'ha;
    alu_valid <= 1;
    @(posedge pclk);
    alu_valid <= 0;
    @(posedge pclk);
    chk(status_flags, 4'ha);
    apb(0, `PSS_OFF_STATUS, 0);
    chk(rd[3:0], 4'ha);
    apb(1, `PSS_OFF_PC_LOW, 32'h1a);
    op(`PSS_OP_SEQ, 0, 0, 0, 13'h11a);
    op(`PSS_OP_JMP, 13'h1e7, 0, 0, 13'h11b);
    // Jumping to itself keeps pc steady for the register read
    apb(0, `PSS_OFF_PC_LOW, 0);
    chk(rd, 32'he7);
    for (int i = 0; i < 9; i++) begin
        if (i == 8) irq_pending <= 1;
        op(`PSS_OP_CALL, 13'h400 + 13'(i * 16), 0, 0,
           i == 0 ? 13'h1e7 : 13'h400 + 13'((i - 1) * 16));
    end
    op(`PSS_OP_RTN, 0, 0, 0, 13'h480);
    chk(n_ack, 0);
    // Pop frees a level, so the held interrupt enters before the next op
    op(`PSS_OP_IRTN, 0, 0, 0, 13'h0800);
    op(`PSS_OP_RTN, 0, 0, 0, 13'h471);
    chk(n_ack, 1);
    for (int i = 5; i >= 0; i--) op(`PSS_OP_RTN, 0, 0, 0, 13'h401 + 13'((i + 1) * 16));
    op(`PSS_OP_SEQ, 0, 0, 0, 13'h401);
    chk(n_ack, 1);
    print_verdict();
end
endmodule // tb_program_sequencer_stack_table_read
